// file: core/pma_pkg.sv
// Constants and types shared by the program memory access path
package pma_pkg;
    // Address and word widths
    localparam int PC_W = 15;
    localparam int WORD_W = 14;
    localparam int MEM_AW = 13;
    localparam int MEM_WORDS = 8192;
    localparam logic [14:0] LAST_ADDR = 15'h1fff;

    // Vectors
    localparam logic [14:0] RESET_VEC = 15'h0000;
    localparam logic [14:0] INT_VEC = 15'h0004;
    localparam logic [14:0] PC_STEP = 15'h0001;

    // Pointer high byte bit that selects program memory
    localparam int PROG_SEL_BIT = 7;

    // Register offsets
    localparam int REG_AW = 3;
    localparam logic [2:0] REG_DATA_LOW = 3'h0;
    localparam logic [2:0] REG_DATA_HIGH = 3'h1;
    localparam logic [2:0] REG_ADDR_LOW = 3'h2;
    localparam logic [2:0] REG_ADDR_HIGH = 3'h3;
    localparam logic [2:0] REG_CTRL = 3'h4;

    // Control register fields
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_BUSY_BIT = 2;

    // Field layouts and fixed bits
    localparam int DATA_HIGH_W = 6;
    localparam int ADDR_HIGH_W = 7;
    localparam logic [1:0] DATA_HIGH_PAD = 2'h0;
    localparam logic ADDR_HIGH_PAD = 1'h1;

    // Reset values
    localparam logic [7:0] DATA_LOW_RST = 8'h00;
    localparam logic [5:0] DATA_HIGH_RST = 6'h00;
    localparam logic [7:0] ADDR_LOW_RST = 8'h00;
    localparam logic [6:0] ADDR_HIGH_RST = 7'h00;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // Indirect access sequencer
    typedef enum logic [1:0] {
        IND_IDLE = 2'b00,
        IND_FETCH = 2'b01,
        IND_DONE = 2'b11
    } pma_ind_e;
endpackage

// file: core/pma_prog_mem.sv
// Program word array with two registered read ports and one write port
`timescale 1ns/1ns
module pma_prog_mem #(
    parameter int AW = 13,
    parameter int DW = 14
) (
    // Clock
    input wire logic clk,
    input wire logic en,
    // Read port A
    input wire logic [AW-1:0] rdAddrA,
    output logic [DW-1:0] rdDataA,
    // Read port B
    input wire logic [AW-1:0] rdAddrB,
    output logic [DW-1:0] rdDataB,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Reads see the old word on a same-cycle write
    always_ff @(posedge clk) begin
        if (en) begin
            rdDataA <= mem[rdAddrA];
            rdDataB <= mem[rdAddrB];
        end
    end

    always_ff @(posedge clk) begin
        if (en && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
endmodule // pma_prog_mem

// file: core/pma_access_path.sv
// Program counter, indirect program reads and nonvolatile holding registers
//
// Behaviour
// - Program counter is fifteen bits wide
// - 8192 words; higher addresses wrap around
// - Reset fetches 0000h; interrupt vectors 0004h
// - Pointer high bit 7 selects program memory
// - Indirect read returns low eight word bits
// - Indirect writes never change program memory
// - Program indirect access takes one extra cycle
// - Data low holds byte or word LSBs
// - Data high holds bits 13:8; 7:6 zero
// - Address low holds LSBs, resets zero
// - Address high bits 14:8; bit7 reads one
`timescale 1ns/1ns
module pma_access_path #(
    parameter int MEM_AW = pma_pkg::MEM_AW
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,

    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,

    // Instruction fetch
    input wire logic pcAdvance,
    input wire logic pcLoad,
    input wire logic [14:0] pcLoadValue,
    input wire logic irqVector,
    output logic [14:0] fetchAddr,
    output logic [13:0] fetchWord,

    // Indirect data port
    input wire logic indRd,
    input wire logic indWr,
    input wire logic [7:0] indPtrHigh,
    input wire logic [7:0] indPtrLow,
    output logic indBusy,
    output logic indDone,
    output logic indIsProg,
    output logic [7:0] indRdData,
    output logic indWrDropped
);
    // Program counter
    logic [14:0] pc_q;
    logic [14:0] pc_d;

    // Holding registers
    logic [7:0] dataLow_q;
    logic [5:0] dataHigh_q;
    logic [7:0] addrLow_q;
    logic [6:0] addrHigh_q;

    // Nonvolatile command state
    logic nvRdPend_q;
    logic nvCapture_q;
    logic nvIssue;
    logic nvWrite;

    // Indirect sequencer
    pma_pkg::pma_ind_e indState_q;
    logic indStart;
    logic indToProg;
    logic indProgRd;
    logic indWrProg_q;
    logic [14:0] indAddr;

    // Combined views
    logic [14:0] nvAddr;
    logic [13:0] nvWord;
    logic [MEM_AW-1:0] memAddrA;
    logic [MEM_AW-1:0] memAddrB;
    logic [13:0] memDataB;

    // Register decode
    logic ctrlWr;
    logic nvRdStart;
    logic wrDataLow;
    logic wrDataHigh;
    logic wrAddrLow;
    logic wrAddrHigh;
    logic [7:0] rdMux;

    assign nvAddr = {addrHigh_q, addrLow_q};
    assign nvWord = {dataHigh_q, dataLow_q};

    // Next program counter
    always_comb begin
        pc_d = pc_q;
        if (!resetn) begin
            pc_d = pma_pkg::RESET_VEC;
        end else if (!clkEn) begin
            pc_d = pc_q;
        end else if (irqVector) begin
            pc_d = pma_pkg::INT_VEC;
        end else if (pcLoad) begin
            pc_d = pcLoadValue;
        end else if (pcAdvance) begin
            pc_d = pc_q + pma_pkg::PC_STEP;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pc_q <= pma_pkg::RESET_VEC;
        end else if (clkEn) begin
            pc_q <= pc_d;
        end
    end

    assign fetchAddr = pc_q;

    // Fetching from the next value keeps the word aligned with fetchAddr
    assign memAddrA = pc_d[MEM_AW-1:0];

    // Indirect request decode
    assign indStart = (indRd || indWr) && (indState_q != pma_pkg::IND_FETCH);
    assign indToProg = indPtrHigh[pma_pkg::PROG_SEL_BIT];
    assign indProgRd = indStart && indRd && indToProg;
    assign indAddr = {indPtrHigh[6:0], indPtrLow};

    // Port B goes to the indirect read first; software reads wait a cycle
    assign nvIssue = nvRdPend_q && !indProgRd;

    always_comb begin
        memAddrB = nvAddr[MEM_AW-1:0];
        if (indProgRd) begin
            memAddrB = indAddr[MEM_AW-1:0];
        end
    end

    // Only the control register writes the array
    assign ctrlWr = regWr && (regAddr == pma_pkg::REG_CTRL);
    assign nvWrite = ctrlWr && regWrData[pma_pkg::CTRL_WR_BIT];
    assign nvRdStart = ctrlWr && regWrData[pma_pkg::CTRL_RD_BIT];

    // One strobe per holding register keeps write and read offsets in step
    assign wrDataLow = regWr && (regAddr == pma_pkg::REG_DATA_LOW);
    assign wrDataHigh = regWr && (regAddr == pma_pkg::REG_DATA_HIGH);
    assign wrAddrLow = regWr && (regAddr == pma_pkg::REG_ADDR_LOW);
    assign wrAddrHigh = regWr && (regAddr == pma_pkg::REG_ADDR_HIGH);

    pma_prog_mem #(
        .AW(MEM_AW),
        .DW(pma_pkg::WORD_W)
    ) u_mem (
        .clk(sys_clk),
        .en(clkEn),
        .rdAddrA(memAddrA),
        .rdDataA(fetchWord),
        .rdAddrB(memAddrB),
        .rdDataB(memDataB),
        .wrEn(nvWrite),
        .wrAddr(nvAddr[MEM_AW-1:0]),
        .wrData(nvWord)
    );

    // Indirect sequencer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indState_q <= pma_pkg::IND_IDLE;
        end else if (clkEn) begin
            unique case (indState_q)
                pma_pkg::IND_IDLE, pma_pkg::IND_DONE: begin
                    if (indStart && indToProg) begin
                        indState_q <= pma_pkg::IND_FETCH;
                    end else if (indStart) begin
                        indState_q <= pma_pkg::IND_DONE;
                    end else begin
                        indState_q <= pma_pkg::IND_IDLE;
                    end
                end
                pma_pkg::IND_FETCH: begin
                    indState_q <= pma_pkg::IND_DONE;
                end
                default: begin
                    indState_q <= pma_pkg::IND_IDLE;
                end
            endcase
        end
    end

    // Busy covers the extra cycle so the core can stall
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indBusy <= 1'b0;
        end else if (clkEn) begin
            indBusy <= indStart && indToProg;
        end
    end

    // Done trails busy by one cycle for program space
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indDone <= 1'b0;
        end else if (clkEn) begin
            indDone <= (indStart && !indToProg) || (indState_q == pma_pkg::IND_FETCH);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indIsProg <= 1'b0;
        end else if (clkEn && indStart) begin
            indIsProg <= indToProg;
        end
    end

    // Remembers a program write so its fetch cycle returns no data
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indWrProg_q <= 1'b0;
        end else if (clkEn && indStart) begin
            indWrProg_q <= indWr && indToProg;
        end
    end

    // Program writes are dropped, only flagged to the core
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indWrDropped <= 1'b0;
        end else if (clkEn) begin
            indWrDropped <= (indState_q == pma_pkg::IND_FETCH) && indWrProg_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            indRdData <= pma_pkg::RD_IDLE;
        end else if (clkEn && (indState_q == pma_pkg::IND_FETCH) && !indWrProg_q) begin
            indRdData <= memDataB[7:0];
        end
    end

    // Software read of a program word
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nvRdPend_q <= 1'b0;
        end else if (clkEn) begin
            if (nvRdStart) begin
                nvRdPend_q <= 1'b1;
            end else if (nvIssue) begin
                nvRdPend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nvCapture_q <= 1'b0;
        end else if (clkEn) begin
            nvCapture_q <= nvIssue;
        end
    end

    // Data low: a returning word outranks a software write
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dataLow_q <= pma_pkg::DATA_LOW_RST;
        end else if (clkEn) begin
            if (nvCapture_q) begin
                dataLow_q <= memDataB[7:0];
            end else if (wrDataLow) begin
                dataLow_q <= regWrData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dataHigh_q <= pma_pkg::DATA_HIGH_RST;
        end else if (clkEn) begin
            if (nvCapture_q) begin
                dataHigh_q <= memDataB[13:8];
            end else if (wrDataHigh) begin
                dataHigh_q <= regWrData[pma_pkg::DATA_HIGH_W-1:0];
            end
        end
    end

    // Address registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            addrLow_q <= pma_pkg::ADDR_LOW_RST;
        end else if (clkEn && wrAddrLow) begin
            addrLow_q <= regWrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            addrHigh_q <= pma_pkg::ADDR_HIGH_RST;
        end else if (clkEn && wrAddrHigh) begin
            addrHigh_q <= regWrData[pma_pkg::ADDR_HIGH_W-1:0];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdMux = pma_pkg::RD_IDLE;
        unique case (regAddr)
            pma_pkg::REG_DATA_LOW: begin
                rdMux = dataLow_q;
            end
            pma_pkg::REG_DATA_HIGH: begin
                rdMux = {pma_pkg::DATA_HIGH_PAD, dataHigh_q};
            end
            pma_pkg::REG_ADDR_LOW: begin
                rdMux = addrLow_q;
            end
            pma_pkg::REG_ADDR_HIGH: begin
                rdMux = {pma_pkg::ADDR_HIGH_PAD, addrHigh_q};
            end
            pma_pkg::REG_CTRL: begin
                rdMux[pma_pkg::CTRL_BUSY_BIT] = nvRdPend_q || nvCapture_q;
            end
            default: begin
                rdMux = pma_pkg::RD_IDLE;
            end
        endcase
    end

    // Read data stand for one cycle only
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            regRdData <= pma_pkg::RD_IDLE;
        end else if (clkEn) begin
            if (regRd) begin
                regRdData <= rdMux;
            end else begin
                regRdData <= pma_pkg::RD_IDLE;
            end
        end
    end
endmodule // pma_access_path

// file: testbench/pma_access_path_asserts.sv
// Port timing checker for the program memory access path
`timescale 1ns/1ns
module pma_access_path_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    // Fetch
    input wire logic pcAdvance,
    input wire logic pcLoad,
    input wire logic irqVector,
    input wire logic [14:0] fetchAddr,
    // Indirect port
    input wire logic indRd,
    input wire logic indWr,
    input wire logic [7:0] indPtrHigh,
    input wire logic indBusy,
    input wire logic indDone,
    input wire logic indIsProg,
    input wire logic indWrDropped
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic take;
    // Requests during a stall are ignored, so they start nothing
    assign take = (indRd || indWr) && !indBusy && clkEn;
    reset_vec_a: assert property (!$past(resetn) |-> fetchAddr == 15'h0000)
        else $error("fetch address not zero after reset");
    irq_vec_a: assert property (irqVector && clkEn |=> fetchAddr == 15'h0004)
        else $error("interrupt vector wrong");
    pc_step_a: assert property (pcAdvance && !pcLoad && !irqVector && clkEn
        |=> fetchAddr == $past(fetchAddr) + 15'h0001)
        else $error("program counter step wrong");
    addr_pad_a: assert property (regRd && clkEn && regAddr == pma_pkg::REG_ADDR_HIGH
        |=> regRdData[7])
        else $error("address high bit 7 not one");
    data_pad_a: assert property (regRd && clkEn && regAddr == pma_pkg::REG_DATA_HIGH
        |=> regRdData[7:6] == 2'h0)
        else $error("data high bits 7:6 not zero");
    prog_extra_a: assert property (take && indPtrHigh[7]
        |=> indBusy && indIsProg && !indDone ##1 indDone && !indBusy)
        else $error("program access timing wrong");
    data_space_a: assert property (take && !indPtrHigh[7]
        |=> indDone && !indBusy && !indIsProg)
        else $error("data access timing wrong");
    wr_drop_a: assert property (take && indWr && indPtrHigh[7] |-> ##2 indWrDropped)
        else $error("program write not dropped");
    cover property (indWrDropped);
    cover property (take && indPtrHigh[7]);
    cover property (irqVector ##1 1'b1);
endmodule // pma_access_path_chk
bind pma_access_path pma_access_path_chk pma_access_path_chk_i (.sys_clk, .resetn, .clkEn,
    .regAddr, .regRd, .regRdData, .pcAdvance, .pcLoad, .irqVector, .fetchAddr, .indRd,
    .indWr, .indPtrHigh, .indBusy, .indDone, .indIsProg, .indWrDropped);

// file: testbench/pma_core_model.sv
// Core-side model issuing indirect accesses
`timescale 1ns/1ns
module pma_core_model (
    // Clock
    input wire logic sys_clk,
    // Indirect port
    input wire logic indDone,
    input wire logic [7:0] indRdData,
    output logic indRd,
    output logic indWr,
    output logic [7:0] indPtrHigh,
    output logic [7:0] indPtrLow
);
    initial begin
        indRd = 1'b0;
        indWr = 1'b0;
        indPtrHigh = 8'h00;
        indPtrLow = 8'h00;
    end
    // One access at a time; the next waits for done
    task automatic access(input logic wr, input logic [7:0] hi, input logic [7:0] lo,
        output logic [7:0] d, output int cyc);
        cyc = 0;
        @(posedge sys_clk);
        indRd <= !wr;
        indWr <= wr;
        indPtrHigh <= hi;
        indPtrLow <= lo;
        @(posedge sys_clk);
        indRd <= 1'b0;
        indWr <= 1'b0;
        do begin
            if (cyc > 0) @(posedge sys_clk);
            #1 cyc++;
        end while (!indDone && cyc < 8);
        d = indRdData;
        // Stale pointer must not look valid
        @(posedge sys_clk);
        indPtrHigh <= ~hi;
        indPtrLow <= ~lo;
    endtask
endmodule // pma_core_model

// file: testbench/pma_access_path_bench.sv
// Self-checking bench for the program memory access path
`timescale 1ns/1ns
module pma_access_path_bench;
    typedef struct packed {
        logic [14:0] wa;
        logic [13:0] wd;
        logic [14:0] ra;
    } pma_row_s;
    localparam pma_row_s ROWS [3] = '{'{15'h0005, 14'h3a5c, 15'h2005},
        '{15'h1fff, 14'h0123, 15'h7fff}, '{15'h0000, 14'h3fff, 15'h4000}};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic pcAdvance = 1'b0;
    logic pcLoad = 1'b0;
    logic irqVector = 1'b0;
    logic clkEn = 1'b1;
    logic [14:0] pcLoadValue = 15'h0000;
    logic [14:0] fetchAddr;
    logic [13:0] fetchWord;
    logic indRd, indWr, indBusy, indDone, indIsProg, indWrDropped;
    logic [7:0] regRdData, indPtrHigh, indPtrLow, indRdData, rdByte;
    int errorCnt = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int indCyc;
    pma_access_path pma_access_path_i (.sys_clk, .resetn, .clkEn, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .pcAdvance, .pcLoad, .pcLoadValue, .irqVector, .fetchAddr,
        .fetchWord, .indRd, .indWr, .indPtrHigh, .indPtrLow, .indBusy, .indDone, .indIsProg,
        .indRdData, .indWrDropped);
    pma_core_model pma_core_model_i (.sys_clk, .indDone, .indRdData, .indRd, .indWr,
        .indPtrHigh, .indPtrLow);
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic reportAndStop();
        $display("checked %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errorCnt++;
            reportAndStop();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rdReg(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic setAddr(input logic [14:0] a);
        wrReg(pma_pkg::REG_ADDR_LOW, a[7:0]);
        wrReg(pma_pkg::REG_ADDR_HIGH, {1'b0, a[14:8]});
    endtask
    task automatic pcOp(input logic ld, input logic adv, input logic irq, input logic [14:0] v);
        @(posedge sys_clk);
        pcLoad <= ld;
        pcAdvance <= adv;
        irqVector <= irq;
        pcLoadValue <= v;
        @(posedge sys_clk);
        pcLoad <= 1'b0;
        pcAdvance <= 1'b0;
        irqVector <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            setAddr(ROWS[i].wa);
            wrReg(pma_pkg::REG_DATA_LOW, ROWS[i].wd[7:0]);
            wrReg(pma_pkg::REG_DATA_HIGH, {2'h0, ROWS[i].wd[13:8]});
            wrReg(pma_pkg::REG_CTRL, 8'h02);
            pma_core_model_i.access(1'b0, {1'b1, ROWS[i].ra[14:8]}, ROWS[i].ra[7:0], rdByte,
                indCyc);
            chk("indirect byte", {8'h00, ROWS[i].wd[7:0]}, {8'h00, rdByte});
            chk("indirect cycles", 16'h0002, 16'(indCyc));
            setAddr(ROWS[i].ra);
            rdReg(pma_pkg::REG_ADDR_HIGH, rdByte);
            chk("address high", {8'h00, 1'b1, ROWS[i].ra[14:8]}, {8'h00, rdByte});
            wrReg(pma_pkg::REG_DATA_LOW, 8'h00);
            wrReg(pma_pkg::REG_DATA_HIGH, 8'hff);
            wrReg(pma_pkg::REG_CTRL, 8'h01);
            repeat (3) @(posedge sys_clk);
            rdReg(pma_pkg::REG_DATA_HIGH, rdByte);
            chk("data high", {10'h000, ROWS[i].wd[13:8]}, {8'h00, rdByte});
            rdReg(pma_pkg::REG_DATA_LOW, rdByte);
            chk("data low", {8'h00, ROWS[i].wd[7:0]}, {8'h00, rdByte});
            $display("row %0d done", i);
        end
        pma_core_model_i.access(1'b1, 8'h80, 8'h05, rdByte, indCyc);
        chk("write cycles", 16'h0002, 16'(indCyc));
        pma_core_model_i.access(1'b0, 8'h80, 8'h05, rdByte, indCyc);
        chk("word after write", 16'h005c, {8'h00, rdByte});
        pma_core_model_i.access(1'b0, 8'h05, 8'h05, rdByte, indCyc);
        chk("data cycles", 16'h0001, 16'(indCyc));
        $display("indirect tests done");
        pcOp(1'b1, 1'b0, 1'b0, 15'h3fff);
        chk("fetch word", 16'h0123, {2'h0, fetchWord});
        pcOp(1'b0, 1'b1, 1'b0, 15'h0000);
        chk("fetch above top", 16'h3fff, {2'h0, fetchWord});
        pcOp(1'b1, 1'b0, 1'b0, 15'h7fff);
        pcOp(1'b0, 1'b1, 1'b0, 15'h0000);
        chk("pc wrap", 16'h0000, {1'b0, fetchAddr});
        pcOp(1'b1, 1'b1, 1'b1, 15'h1234);
        chk("irq vector", 16'h0004, {1'b0, fetchAddr});
        // Frozen edges must leave the counter alone
        @(posedge sys_clk);
        clkEn <= 1'b0;
        pcAdvance <= 1'b1;
        repeat (2) @(posedge sys_clk);
        clkEn <= 1'b1;
        pcAdvance <= 1'b0;
        #1;
        chk("frozen pc", 16'h0004, {1'b0, fetchAddr});
        rdReg(3'h5, rdByte);
        chk("unmapped", 16'h0000, {8'h00, rdByte});
        $display("fetch tests done");
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk("reset pc", 16'h0000, {1'b0, fetchAddr});
        rdReg(pma_pkg::REG_ADDR_LOW, rdByte);
        chk("address low reset", 16'h0000, {8'h00, rdByte});
        rdReg(pma_pkg::REG_ADDR_HIGH, rdByte);
        chk("address high reset", 16'h0080, {8'h00, rdByte});
        $display("reset test done");
        reportAndStop();
    end
endmodule // pma_access_path_bench
